// ===== rtl/dcr_ahb_slave.sv
// ahb-lite slave front end with one wait state per transfer
`timescale 1ns/1ps
`include "dcr_params.svh"

module dcr_ahb_slave (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    input wire logic [31:0] rd_data_in,
    output logic wr_en_out,
    output logic [`DCR_ADDR_W-1:0] addr_out,
    output logic [31:0] wdata_out,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);

    dcr_pkg::dcr_ahb_state_type state_reg;
    logic write_reg;
    logic [`DCR_ADDR_W-1:0] addr_reg;
    logic accept;

    // nonseq or seq taken alike; only whole words are expected
    assign accept = hsel_in & htrans_in[1] & hready_in;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_reg <= dcr_pkg::AHB_IDLE;
        end else if (accept) begin
            state_reg <= dcr_pkg::AHB_DATA;
        end else begin
            state_reg <= dcr_pkg::AHB_IDLE;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            addr_reg <= '0;
            write_reg <= 1'b0;
        end else if (accept) begin
            addr_reg <= haddr_in[`DCR_ADDR_W-1:0];
            write_reg <= hwrite_in;
        end
    end

    // read data captured in the wait cycle so hrdata comes from a flop
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hrdata_out <= `DCR_WORD_RST;
        end else if (state_reg == dcr_pkg::AHB_DATA && !write_reg) begin
            hrdata_out <= rd_data_in;
        end
    end

    assign wr_en_out = (state_reg == dcr_pkg::AHB_DATA) & write_reg;
    assign addr_out = addr_reg;
    assign wdata_out = hwdata_in;
    assign hreadyout_out = (state_reg == dcr_pkg::AHB_IDLE);
    assign hresp_out = 1'b0;

endmodule

// ===== rtl/dcr_params.svh
// register map, field positions and reset values of the completion and receive state block
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

// register byte offsets, decoded on the low address bits
`define DCR_ADDR_W 8
`define DCR_OFF_TX_COMP 8'h00
`define DCR_OFF_RX_SKIP 8'h04
`define DCR_OFF_RX_HEAD 8'h08
`define DCR_OFF_RX_FIRST 8'h0C
`define DCR_OFF_INT_STATUS 8'h10
`define DCR_OFF_INT_CLEAR 8'h14
`define DCR_OFF_INT_ENABLE 8'h18

// field positions
`define DCR_PTR_MSB 31
`define DCR_PTR_LSB 2
`define DCR_PTR_W 30
`define DCR_MODE_BIT 0
`define DCR_IN_PACKET_BIT 0
`define DCR_SKIP_MSB 7
`define DCR_SKIP_W 8

// interrupt event bits
`define DCR_NUM_EV 3
`define DCR_EV_TX_WRITEBACK 0
`define DCR_EV_RX_START 1
`define DCR_EV_RX_END 2

// reset values and the receive write address step
`define DCR_PTR_RST 30'h0000_0000
`define DCR_SKIP_RST 8'h00
`define DCR_BYTE_RST 8'h00
`define DCR_EV_RST 3'h0
`define DCR_WORD_RST 32'h0000_0000
`define DCR_ADDR_STEP 32'h0000_0001

`endif

// ===== rtl/dcr_pkg.sv
// shared types of the completion and receive state block
package dcr_pkg;

    // bus slave phase: waiting for an address phase or serving a data phase
    typedef enum logic {
        AHB_IDLE,
        AHB_DATA
    } dcr_ahb_state_type;

endpackage

// ===== rtl/dcr_top.sv
// transmit completion pointer and receive channel state words with bus access
// Function
// (R1) mode-0 write compares bits 31:2 with pointer; match drops queue interrupt, pointer kept.
// (R2) mode-1 write stores bits 31:2 as pointer and raises queue interrupt.
// (R3) the writeback/compare select bit always reads as zero.
// (R4) completion pointer holds word address of last finished end-of-packet descriptor.
// (R5) first buffer of each packet skips the programmed byte count before data.
// (R6) software programs the skip count while setting up the receive channel.
// (R7) state word 1 bits 31:2 hold the receive queue head descriptor pointer.
// (R8) state word 2 bits 31:2 hold the first descriptor of current packet.
// (R9) state word 2 bit 0 is one inside a packet, zero outside.
// (R10) reserved bits of these words read zero and ignore writes.
// (R11) queue interrupt stays set from writeback until a matching compare write.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "dcr_params.svh"

module dcr_top (
    input wire logic clk_in,
    input wire logic resetn_in,
    // ahb-lite register port
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // transmit dma completion
    input wire logic tx_eop_done_in,
    input wire logic [`DCR_PTR_W-1:0] tx_eop_desc_in,
    // receive dma descriptor walk
    input wire logic rx_sop_in,
    input wire logic rx_eop_in,
    input wire logic rx_buf_load_in,
    input wire logic [31:0] rx_buf_addr_in,
    input wire logic rx_head_adv_in,
    input wire logic [`DCR_PTR_W-1:0] rx_head_next_in,
    // receive byte stream into memory
    input wire logic rx_byte_valid_in,
    input wire logic [7:0] rx_byte_in,
    output logic mem_wr_valid_out,
    output logic [31:0] mem_wr_addr_out,
    output logic [7:0] mem_wr_data_out,
    // status and interrupts
    output logic rx_in_packet_out,
    output logic txq_irq_out,
    output logic irq_out
);

    logic bus_wr_en;
    logic [`DCR_ADDR_W-1:0] bus_addr;
    logic [31:0] bus_wdata;
    logic [31:0] rd_data;

    logic [`DCR_PTR_W-1:0] tx_ptr_reg;
    logic txq_irq_reg;
    logic [`DCR_SKIP_W-1:0] skip_reg;
    logic [`DCR_PTR_W-1:0] head_reg;
    logic [`DCR_PTR_W-1:0] first_reg;
    logic in_packet_reg;
    logic [`DCR_NUM_EV-1:0] status_reg;
    logic [`DCR_NUM_EV-1:0] status_next;
    logic [`DCR_NUM_EV-1:0] enable_reg;
    logic [`DCR_NUM_EV-1:0] events;
    logic [31:0] wr_addr_reg;
    logic mem_valid_reg;
    logic [31:0] mem_addr_reg;
    logic [7:0] mem_data_reg;

    logic wr_tx;
    logic wr_skip;
    logic wr_head;
    logic wr_first;
    logic wr_clear;
    logic wr_enable;
    logic wr_mode;
    logic [`DCR_PTR_W-1:0] wr_ptr;
    logic tx_writeback;
    logic tx_match;
    logic byte_fire;

    logic dma_tx_writeback;
    logic sw_tx_writeback;
    logic [`DCR_SKIP_W-1:0] wr_skip_val;
    logic wr_in_packet;
    logic [`DCR_NUM_EV-1:0] wr_ev_mask;
    logic [`DCR_NUM_EV-1:0] pending;
    logic [31:0] sop_start_addr;

    logic [31:0] rd_tx_word;
    logic [31:0] rd_skip_word;
    logic [31:0] rd_head_word;
    logic [31:0] rd_first_word;
    logic [31:0] rd_status_word;
    logic [31:0] rd_enable_word;

    // one wait state per transfer keeps read data in a flop
    // hsize is not decoded: every access is taken as a whole word
    dcr_ahb_slave u_slave (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .hsel_in(hsel_in),
        .haddr_in(haddr_in),
        .htrans_in(htrans_in),
        .hwrite_in(hwrite_in),
        .hwdata_in(hwdata_in),
        .hready_in(hready_in),
        .rd_data_in(rd_data),
        .wr_en_out(bus_wr_en),
        .addr_out(bus_addr),
        .wdata_out(bus_wdata),
        .hrdata_out(hrdata_out),
        .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out)
    );

    // write decode
    // only the low address byte is decoded, so the map repeats every 256 bytes
    assign wr_tx = bus_wr_en && (bus_addr == `DCR_OFF_TX_COMP);
    assign wr_skip = bus_wr_en && (bus_addr == `DCR_OFF_RX_SKIP);
    assign wr_head = bus_wr_en && (bus_addr == `DCR_OFF_RX_HEAD);
    assign wr_first = bus_wr_en && (bus_addr == `DCR_OFF_RX_FIRST);
    assign wr_clear = bus_wr_en && (bus_addr == `DCR_OFF_INT_CLEAR);
    assign wr_enable = bus_wr_en && (bus_addr == `DCR_OFF_INT_ENABLE);

    // write data fields; bits outside them are reserved and dropped here
    assign wr_mode = bus_wdata[`DCR_MODE_BIT];
    assign wr_ptr = bus_wdata[`DCR_PTR_MSB:`DCR_PTR_LSB];
    assign wr_skip_val = bus_wdata[`DCR_SKIP_MSB:0];
    assign wr_in_packet = bus_wdata[`DCR_IN_PACKET_BIT];
    assign wr_ev_mask = bus_wdata[`DCR_NUM_EV-1:0];

    // either the dma or software may write back a completion
    assign dma_tx_writeback = tx_eop_done_in;
    assign sw_tx_writeback = wr_tx & wr_mode;
    assign tx_writeback = dma_tx_writeback | sw_tx_writeback;

    // (R1) compare against stored pointer
    assign tx_match = wr_tx & ~wr_mode & (wr_ptr == tx_ptr_reg);

    // (R4) last finished end-of-packet descriptor
    // (R2) writeback stores the pointer
    // the dma wins a same-cycle collision with a software writeback
    // the losing software value is dropped, not queued
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_ptr_reg <= `DCR_PTR_RST;
        end else if (dma_tx_writeback) begin
            tx_ptr_reg <= tx_eop_desc_in;
        end else if (sw_tx_writeback) begin
            tx_ptr_reg <= wr_ptr;
        end
    end

    // (R11) sticky queue interrupt
    // (R2) writeback raises it, and wins over a same-cycle compare
    // (R1) a matching compare drops it
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            txq_irq_reg <= 1'b0;
        end else if (tx_writeback) begin
            txq_irq_reg <= 1'b1;
        end else if (tx_match) begin
            txq_irq_reg <= 1'b0;
        end
    end

    // (R6) skip count set by software at channel setup
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            skip_reg <= `DCR_SKIP_RST;
        end else if (wr_skip) begin
            skip_reg <= wr_skip_val;
        end
    end

    // (R7) queue head follows the descriptor walk
    // dma advance takes priority over a software write in the same cycle
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            head_reg <= `DCR_PTR_RST;
        end else if (rx_head_adv_in) begin
            head_reg <= rx_head_next_in;
        end else if (wr_head) begin
            head_reg <= wr_ptr;
        end
    end

    // (R8) first descriptor captured from the head at packet start
    // the head before a same-cycle advance is the packet's first descriptor
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            first_reg <= `DCR_PTR_RST;
        end else if (rx_sop_in) begin
            first_reg <= head_reg;
        end else if (wr_first) begin
            first_reg <= wr_ptr;
        end
    end

    // (R9) in-packet flag
    // start and end together mean a packet already closed
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            in_packet_reg <= 1'b0;
        end else if (rx_eop_in) begin
            in_packet_reg <= 1'b0;
        end else if (rx_sop_in) begin
            in_packet_reg <= 1'b1;
        end else if (wr_first) begin
            in_packet_reg <= wr_in_packet;
        end
    end

    // (R5) skipped bytes are never written, leaving room for a header
    // the sum wraps at the top of the address space
    assign sop_start_addr = rx_buf_addr_in + 32'(skip_reg);

    // (R5) skip only in the start-of-packet buffer
    // later buffers of the packet start at their first byte
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wr_addr_reg <= `DCR_WORD_RST;
        end else if (rx_sop_in) begin
            wr_addr_reg <= sop_start_addr;
        end else if (rx_buf_load_in) begin
            wr_addr_reg <= rx_buf_addr_in;
        end else if (byte_fire) begin
            wr_addr_reg <= wr_addr_reg + `DCR_ADDR_STEP;
        end
    end

    // bytes outside a packet have nowhere to go and are dropped
    assign byte_fire = rx_byte_valid_in & in_packet_reg;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_valid_reg <= 1'b0;
        end else begin
            mem_valid_reg <= byte_fire;
        end
    end

    // address and data hold until the next accepted byte
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_addr_reg <= `DCR_WORD_RST;
        end else if (byte_fire) begin
            mem_addr_reg <= wr_addr_reg;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_data_reg <= `DCR_BYTE_RST;
        end else if (byte_fire) begin
            mem_data_reg <= rx_byte_in;
        end
    end

    // interrupt events
    always_comb begin
        events = `DCR_EV_RST;
        events[`DCR_EV_TX_WRITEBACK] = tx_writeback;
        events[`DCR_EV_RX_START] = rx_sop_in;
        events[`DCR_EV_RX_END] = rx_eop_in;
    end

    // a new event beats a clear of the same bit
    always_comb begin
        status_next = status_reg;
        if (wr_clear) begin
            status_next = status_next & ~wr_ev_mask;
        end
        status_next = status_next | events;
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_reg <= `DCR_EV_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            enable_reg <= `DCR_EV_RST;
        end else if (wr_enable) begin
            enable_reg <= wr_ev_mask;
        end
    end

    // (R10) reserved bits packed as zero in every read word
    // (R3) select bit never stored, reads zero
    assign rd_tx_word = {tx_ptr_reg, 2'b00};
    assign rd_skip_word = 32'(skip_reg);
    assign rd_head_word = {head_reg, 2'b00};
    assign rd_first_word = {first_reg, 1'b0, in_packet_reg};
    assign rd_status_word = 32'(status_reg);
    assign rd_enable_word = 32'(enable_reg);

    // read mux; unmapped and write-only offsets read zero
    always_comb begin
        rd_data = `DCR_WORD_RST;
        unique case (bus_addr)
            `DCR_OFF_TX_COMP: begin
                rd_data = rd_tx_word;
            end
            `DCR_OFF_RX_SKIP: begin
                rd_data = rd_skip_word;
            end
            `DCR_OFF_RX_HEAD: begin
                rd_data = rd_head_word;
            end
            `DCR_OFF_RX_FIRST: begin
                rd_data = rd_first_word;
            end
            `DCR_OFF_INT_STATUS: begin
                rd_data = rd_status_word;
            end
            `DCR_OFF_INT_ENABLE: begin
                rd_data = rd_enable_word;
            end
            default: begin
                rd_data = `DCR_WORD_RST;
            end
        endcase
    end

    assign mem_wr_valid_out = mem_valid_reg;
    assign mem_wr_addr_out = mem_addr_reg;
    assign mem_wr_data_out = mem_data_reg;
    assign rx_in_packet_out = in_packet_reg;
    assign txq_irq_out = txq_irq_reg;
    // level output: high until the bit is cleared or masked
    assign pending = status_reg & enable_reg;
    assign irq_out = |pending;

endmodule

// ===== tb/dcr_mem_model.sv
// byte-wide system memory taking the receive dma writes
`timescale 1ns/1ps
module dcr_mem_model (
    input wire logic clk_in,
    input wire logic wr_valid_in,
    input wire logic [31:0] wr_addr_in,
    input wire logic [7:0] wr_data_in
);
    logic [7:0] mem [logic [31:0]];
    // skipped bytes stay absent
    // sampled mid-cycle, away from the edge that launches the write
    always @(negedge clk_in) begin
        if (wr_valid_in === 1'b1) begin
            mem[wr_addr_in] = wr_data_in;
        end
    end
endmodule

// ===== tb/dcr_monitor.sv
// concurrent checks on the ports of the completion and receive state block
`timescale 1ns/1ps
`include "dcr_params.svh"
module dcr_monitor (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic rx_sop_in,
    input wire logic rx_eop_in,
    input wire logic rx_buf_load_in,
    input wire logic rx_byte_valid_in,
    input wire logic [7:0] rx_byte_in,
    input wire logic mem_wr_valid_out,
    input wire logic [31:0] mem_wr_addr_out,
    input wire logic [7:0] mem_wr_data_out,
    input wire logic rx_in_packet_out,
    input wire logic txq_irq_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    logic take;
    // a byte counts only while inside a packet
    assign take = rx_byte_valid_in && rx_in_packet_out;
    sequence s_addr;
        hsel_in && htrans_in[1] && hready_in;
    endsequence
    sequence s_wait;
        !hreadyout_out ##1 hreadyout_out;
    endsequence
    AST_ONE_WAIT: assert property (s_addr |=> s_wait)
        else $error("bus wait is not one cycle");
    AST_OKAY: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    AST_BYTE_WR: assert property (take |=> mem_wr_valid_out && mem_wr_data_out == $past(rx_byte_in))
        else $error("accepted byte not written");
    AST_BYTE_DROP: assert property (!take |=> !mem_wr_valid_out)
        else $error("memory write without accepted byte");
    AST_ADDR_STEP: assert property (take && mem_wr_valid_out && !rx_sop_in && !rx_buf_load_in
        && !$past(rx_sop_in) && !$past(rx_buf_load_in)
        |=> mem_wr_addr_out == $past(mem_wr_addr_out) + 32'h0000_0001)
        else $error("write address did not step by one");
    AST_SOP_SET: assert property (rx_sop_in && !rx_eop_in |=> rx_in_packet_out)
        else $error("packet start did not set flag");
    AST_EOP_CLR: assert property (rx_eop_in |=> !rx_in_packet_out)
        else $error("packet end did not clear flag");
    AST_PKT_HOLD: assert property (rx_in_packet_out && !rx_eop_in && hreadyout_out
        |=> rx_in_packet_out)
        else $error("packet flag dropped on its own");
    AST_IRQ_HOLD: assert property (txq_irq_out && hreadyout_out |=> txq_irq_out)
        else $error("queue interrupt dropped without compare write");
endmodule

// ===== tb/dma_completion_and_rx_state_tb.sv
// self-checking bench for the completion and receive state block
`timescale 1ns/1ps
`include "dcr_params.svh"
module dma_completion_and_rx_state_tb;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic hsel_in = 1'b0, hwrite_in = 1'b0, tx_eop_done_in = 1'b0, rx_sop_in = 1'b0;
    logic rx_eop_in = 1'b0, rx_buf_load_in = 1'b0, rx_head_adv_in = 1'b0;
    logic rx_byte_valid_in = 1'b0, rdy;
    logic [1:0] htrans_in = 2'h0;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rx_buf_addr_in = 32'h0, rdat, hrd;
    logic [29:0] tx_eop_desc_in = 30'h0, rx_head_next_in = 30'h0;
    logic [7:0] rx_byte_in = 8'h0;
    wire logic hreadyout_out, hresp_out, mem_wr_valid_out, rx_in_packet_out;
    wire logic txq_irq_out, irq_out;
    wire logic [31:0] hrdata_out, mem_wr_addr_out;
    wire logic [7:0] mem_wr_data_out;
    int mismatches = 0;
    int samples_checked = 0;
    always #12.5 clk_in = ~clk_in;
    // ready and read data seen mid-cycle are the values the next edge samples
    always @(negedge clk_in) begin
        rdy = hreadyout_out;
        hrd = hrdata_out;
    end
    dcr_top u_dut (.clk_in, .resetn_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
        .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
        .hreadyout_out, .hresp_out, .tx_eop_done_in, .tx_eop_desc_in, .rx_sop_in,
        .rx_eop_in, .rx_buf_load_in, .rx_buf_addr_in, .rx_head_adv_in, .rx_head_next_in,
        .rx_byte_valid_in, .rx_byte_in, .mem_wr_valid_out, .mem_wr_addr_out,
        .mem_wr_data_out, .rx_in_packet_out, .txq_irq_out, .irq_out);
    dcr_mem_model u_mem (.clk_in, .wr_valid_in(mem_wr_valid_out),
        .wr_addr_in(mem_wr_addr_out), .wr_data_in(mem_wr_data_out));
    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= w;
        @(posedge clk_in);
        while (rdy !== 1'b1) @(posedge clk_in);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        @(posedge clk_in);
        while (rdy !== 1'b1) @(posedge clk_in);
        rdat = hrd;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp(rdat, exp);
    endtask
    task automatic flags(input logic [2:0] exp);
        @(negedge clk_in);
        cmp({29'h0, rx_in_packet_out, txq_irq_out, irq_out}, {29'h0, exp});
    endtask
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 7; i++) rd(32'(i * 4), 32'h0);
        bus(1'b1, 32'h04, 32'hFFFF_FF05);
        rd(32'h04, 32'h0000_0005);
        bus(1'b1, 32'h08, 32'hFFFF_FFFF);
        rd(32'h08, 32'hFFFF_FFFC);
        bus(1'b1, 32'h0C, 32'hFFFF_FFFF);
        rd(32'h0C, 32'hFFFF_FFFD);
        bus(1'b1, 32'h0C, 32'h0);
        bus(1'b1, 32'h40, 32'hFFFF_FFFF);
        rd(32'h40, 32'h0);
        bus(1'b1, 32'h08, 32'h0000_0100);
        @(posedge clk_in);
        rx_head_adv_in <= 1'b1;
        rx_head_next_in <= 30'h50;
        @(posedge clk_in);
        rx_head_adv_in <= 1'b0;
        rd(32'h08, 32'h0000_0140);
        bus(1'b1, 32'h18, 32'h7);
        @(posedge clk_in);
        rx_sop_in <= 1'b1;
        rx_buf_addr_in <= 32'h2000;
        rx_byte_valid_in <= 1'b1;
        rx_byte_in <= 8'hEE;
        @(posedge clk_in);
        rx_sop_in <= 1'b0;
        rx_byte_in <= 8'hA1;
        @(posedge clk_in);
        rx_byte_in <= 8'hA2;
        @(posedge clk_in);
        rx_byte_valid_in <= 1'b0;
        rx_buf_load_in <= 1'b1;
        rx_buf_addr_in <= 32'h3000;
        @(posedge clk_in);
        rx_buf_load_in <= 1'b0;
        rx_byte_valid_in <= 1'b1;
        rx_byte_in <= 8'hB3;
        @(posedge clk_in);
        rx_byte_valid_in <= 1'b0;
        flags(3'b101);
        rd(32'h0C, 32'h0000_0141);
        @(posedge clk_in);
        rx_eop_in <= 1'b1;
        @(posedge clk_in);
        rx_eop_in <= 1'b0;
        flags(3'b001);
        rd(32'h10, 32'h6);
        cmp({24'h0, u_mem.mem[32'h2005]}, 32'hA1);
        cmp({24'h0, u_mem.mem[32'h2006]}, 32'hA2);
        cmp({24'h0, u_mem.mem[32'h3000]}, 32'hB3);
        cmp(32'(u_mem.mem.exists(32'h2004)), 32'h0);
        bus(1'b1, 32'h14, 32'h6);
        rd(32'h10, 32'h0);
        bus(1'b1, 32'h00, 32'h1234_5679);
        flags(3'b011);
        rd(32'h00, 32'h1234_5678);
        bus(1'b1, 32'h18, 32'h0);
        flags(3'b010);
        bus(1'b1, 32'h00, 32'h8765_4320);
        flags(3'b010);
        rd(32'h00, 32'h1234_5678);
        bus(1'b1, 32'h00, 32'h1234_5678);
        flags(3'b000);
        @(posedge clk_in);
        tx_eop_done_in <= 1'b1;
        tx_eop_desc_in <= 30'h0ABC_DEF0;
        @(posedge clk_in);
        tx_eop_done_in <= 1'b0;
        rd(32'h00, 32'h2AF3_7BC0);
        bus(1'b1, 32'h00, 32'hFFFF_FFFF);
        rd(32'h00, 32'hFFFF_FFFC);
        // reset in mid-run returns every word and flag to zero
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        resetn_in <= 1'b1;
        flags(3'b000);
        rd(32'h00, 32'h0);
        rd(32'h0C, 32'h0);
        finish_test();
    end
endmodule
bind dcr_top dcr_monitor u_mon (.clk_in, .resetn_in, .hsel_in, .htrans_in, .hready_in,
    .hreadyout_out, .hresp_out, .rx_sop_in, .rx_eop_in, .rx_buf_load_in, .rx_byte_valid_in,
    .rx_byte_in, .mem_wr_valid_out, .mem_wr_addr_out, .mem_wr_data_out, .rx_in_packet_out,
    .txq_irq_out);
